/* logic/scm_pkg.sv */
// Package of constants and types for the channel mode and interrupt block
// How it works
// - Two-bit field picks x1, x16, x32, x64
// - Start detect only at x16/x32/x64
// - Sync field picks 8/16-bit, flag, external
// - Stop field: sync, 1, 1.5, 2 bits
// - Sense bit: 1 even, 0 odd
// - Parity bit appended; passed unless eight-bit
// - Both registers clear on any reset
// - Polynomial bit picks CRC-16 or bit-oriented
// - CRC preset ones in flag mode, else zeros
// - Transmit strobe pulses low three cycles
// - Receive strobe pulses low three cycles
// - Receive interrupt mode field, four choices
// - Special conditions; overrun, parity latched
// - Disabled mode cancels; re-enable raises at once
// - First-char mode; special data held
// - Fixed vector or 0fh unless status-affects
// - Three vector bits encode source
// - Status-affects ORed; transmit interrupt on empty
// - Error reset clears latched flags
// - Re-arm command restores first-char mode
package scm_pkg;
  localparam logic [2:0] SCM_OFS_FORMAT = 3'h0;
  localparam logic [2:0] SCM_OFS_INTERRUPT_HANDSHAKE_CONTROL = 3'h1;
  localparam logic [2:0] SCM_OFS_CMD = 3'h2;
  localparam logic [2:0] SCM_OFS_VECTOR = 3'h3;
  localparam logic [2:0] SCM_OFS_STATUS = 3'h4;
  localparam logic [7:0] SCM_RST_FORMAT = 8'h00;
  localparam logic [7:0] SCM_RST_INTERRUPT_HANDSHAKE_CONTROL = 8'h00;
  localparam logic [7:0] SCM_RST_VECTOR = 8'h00;
  localparam logic [7:0] SCM_VEC_UNPROG = 8'h0f;
  // Format register fields
  localparam int SCM_FMT_RATE = 6;
  localparam int SCM_FMT_SYNC = 4;
  localparam int SCM_FMT_STOP = 2;
  localparam int SCM_FMT_EVEN = 1;
  localparam int SCM_FMT_PAR = 0;
  // Interrupt control fields
  localparam int SCM_INT_POLY = 7;
  localparam int SCM_INT_TRANSMIT_REQUEST_STROBE = 6;
  localparam int SCM_INT_RECEIVE_REQUEST_STROBE = 5;
  localparam int SCM_INT_RXMODE = 3;
  localparam int SCM_INT_SAV = 2;
  localparam int SCM_INT_TXIE = 1;
  // Command field and codes
  localparam int SCM_CMD_POS = 3;
  localparam logic [2:0] SCM_CMD_CHAN_RESET = 3'h3;
  localparam logic [2:0] SCM_CMD_NEXT_CHAR = 3'h4;
  localparam logic [2:0] SCM_CMD_TX_INT_RESET = 3'h5;
  localparam logic [2:0] SCM_CMD_ERR_RESET = 3'h6;
  // Status register flag positions
  localparam int SCM_ST_EOF = 7;
  localparam int SCM_ST_FRAME = 6;
  localparam int SCM_ST_OVERRUN = 5;
  localparam int SCM_ST_PARITY = 4;
  localparam int SCM_ST_HELD = 1;
  localparam int SCM_ST_SAV_ANY = 0;
  // Vector source field
  localparam int SCM_VEC_SRC_LSB = 1;
  localparam int SCM_STROBE_CYCLES = 3;
  typedef enum logic [1:0] {
    SCM_X1, SCM_X16, SCM_X32, SCM_X64
  } scm_rate_t;
  typedef enum logic [1:0] {
    SCM_SYNC8, SCM_SYNC16, SCM_FLAG, SCM_EXTSYNC
  } scm_sync_t;
  typedef enum logic [1:0] {
    SCM_STOP_SYNC, SCM_STOP_1, SCM_STOP_1P5, SCM_STOP_2
  } scm_stop_t;
  typedef enum logic [1:0] {
    SCM_RX_OFF, SCM_RX_FIRST, SCM_RX_ALL_PE, SCM_RX_ALL
  } scm_rxmode_t;
  // Pending source bits, index equals low vector code
  localparam int SCM_SRC_TX = 0;
  localparam int SCM_SRC_EXT = 1;
  localparam int SCM_SRC_RX = 2;
  localparam int SCM_SRC_SPECIAL = 3;
endpackage : scm_pkg

/* logic/scm_strobe.sv */
// Three-cycle active-low request strobe generator
`timescale 1ns/1ns
module scm_strobe #(
  parameter int CYCLES = scm_pkg::SCM_STROBE_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic trig,
  output logic strobe_n
);
  logic [3:0] cnt_reg;

  // Trigger in the first two low cycles is absorbed; in the third it restarts the pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= 4'h0;
      strobe_n <= 1'b1;
    end else if (trig && cnt_reg == 4'h0) begin
      cnt_reg <= 4'(CYCLES - 1);
      strobe_n <= 1'b0;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
      strobe_n <= 1'b0;
    end else begin
      strobe_n <= 1'b1;
    end
  end
endmodule : scm_strobe

/* logic/scm_vector.sv */
// Priority encoder for the variable interrupt vector field
`timescale 1ns/1ns
module scm_vector (
  input wire logic [3:0] pend_a,
  input wire logic [3:0] pend_b,
  output logic any,
  output logic [2:0] src
);
  // Special over receive over transmit over external
  function automatic logic [1:0] scm_pick(input logic [3:0] p);
    logic [1:0] r;
    r = 2'(scm_pkg::SCM_SRC_EXT);
    if (p[scm_pkg::SCM_SRC_SPECIAL]) begin
      r = 2'(scm_pkg::SCM_SRC_SPECIAL);
    end else if (p[scm_pkg::SCM_SRC_RX]) begin
      r = 2'(scm_pkg::SCM_SRC_RX);
    end else if (p[scm_pkg::SCM_SRC_TX]) begin
      r = 2'(scm_pkg::SCM_SRC_TX);
    end
    return r;
  endfunction : scm_pick

  always_comb begin
    any = (pend_a != 4'h0) || (pend_b != 4'h0);
    if (pend_a != 4'h0) begin
      src = {1'b1, scm_pick(pend_a)};
    end else begin
      src = {1'b0, scm_pick(pend_b)};
    end
  end
endmodule : scm_vector

/* logic/scm_channel.sv */
// One channel of format, interrupt and handshake control
`timescale 1ns/1ns
module scm_channel #(
  parameter bit IS_CH_A = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic char_boundary,
  input wire logic rx_eight_bits,
  input wire logic [7:0] tx_char,
  input wire logic tx_empty_evt,
  input wire logic tx_load,
  input wire logic rx_char_evt,
  input wire logic rx_char_avail,
  input wire logic rx_char_read,
  input wire logic overrun_evt,
  input wire logic parity_err_evt,
  input wire logic framing_err_evt,
  input wire logic end_of_frame_evt,
  input wire logic ext_status_pend,
  input wire logic other_sav,
  input wire logic [3:0] other_pend,
  output logic [1:0] clock_ratio,
  output logic start_detect_en,
  output logic sync_active,
  output logic [1:0] sync_mode,
  output logic [1:0] stop_bits,
  output logic parity_en,
  output logic parity_even,
  output logic tx_parity_bit,
  output logic rx_keep_parity,
  output logic polynomial_select,
  output logic crc_preset_ones,
  output logic rx_hold_data,
  output logic transmit_request_strobe,
  output logic receive_request_strobe,
  output logic [3:0] chan_pend,
  output logic sav_out,
  output logic int_req,
  output logic [7:0] vector_out
);
  logic [7:0] fmt_reg;
  logic [7:0] interrupt_handshake_control_reg;
  logic [7:0] vector_reg;
  logic vec_prog_reg;
  logic [7:0] act_reg;
  logic [3:0] err_reg;
  logic first_armed_reg;
  logic first_pend_reg;
  logic tx_pend_reg;
  logic cmd_wr;
  logic chan_rst;
  logic err_rst;
  logic is_sync;
  logic special;
  logic [1:0] rx_mode;
  logic [3:0] pend;
  logic enc_any;
  logic [2:0] enc_src;
  logic [3:0] pend_a;
  logic [3:0] pend_b;
  logic sav_eff;
  logic tx_trig;
  logic rx_trig;

  // Even parity bit is the XOR, odd its inverse
  function automatic logic scm_parity(input logic [7:0] d, input logic ev);
    return ^d ^ ~ev;
  endfunction : scm_parity

  assign cmd_wr = wr && addr == scm_pkg::SCM_OFS_CMD;
  assign chan_rst = cmd_wr &&
    wdata[scm_pkg::SCM_CMD_POS +: 3] == scm_pkg::SCM_CMD_CHAN_RESET;
  assign err_rst = cmd_wr &&
    wdata[scm_pkg::SCM_CMD_POS +: 3] == scm_pkg::SCM_CMD_ERR_RESET;
  assign is_sync = act_reg[scm_pkg::SCM_FMT_STOP +: 2] ==
    2'(scm_pkg::SCM_STOP_SYNC);
  assign rx_mode = interrupt_handshake_control_reg[scm_pkg::SCM_INT_RXMODE +: 2];
  assign sav_eff = interrupt_handshake_control_reg[scm_pkg::SCM_INT_SAV] | other_sav;

  // Special receive condition from the latched flags only
  assign special = err_reg[3:1] != 3'h0 ||
    (rx_mode == 2'(scm_pkg::SCM_RX_ALL_PE) && err_reg[0]);

  // Format and interrupt control registers
  always_ff @(posedge clk) begin
    if (srst || chan_rst) begin
      fmt_reg <= scm_pkg::SCM_RST_FORMAT;
      interrupt_handshake_control_reg <= scm_pkg::SCM_RST_INTERRUPT_HANDSHAKE_CONTROL;
    end else if (wr && addr == scm_pkg::SCM_OFS_FORMAT) begin
      fmt_reg <= wdata;
    end else if (wr && addr == scm_pkg::SCM_OFS_INTERRUPT_HANDSHAKE_CONTROL) begin
      interrupt_handshake_control_reg <= wdata;
    end
  end

  // Vector survives channel reset; hardware reset marks unprogrammed
  always_ff @(posedge clk) begin
    if (srst) begin
      vector_reg <= scm_pkg::SCM_RST_VECTOR;
      vec_prog_reg <= 1'b0;
    end else if (wr && addr == scm_pkg::SCM_OFS_VECTOR) begin
      vector_reg <= wdata;
      vec_prog_reg <= 1'b1;
    end
  end

  // Active format taken only between characters
  always_ff @(posedge clk) begin
    if (srst || chan_rst) begin
      act_reg <= scm_pkg::SCM_RST_FORMAT;
    end else if (char_boundary) begin
      act_reg <= fmt_reg;
    end
  end

  // Latched flags: {eof, framing, overrun, parity}; set wins over clear
  always_ff @(posedge clk) begin
    if (srst || chan_rst) begin
      err_reg <= 4'h0;
    end else begin
      err_reg <= (err_rst ? 4'h0 : err_reg) | {
        end_of_frame_evt && is_sync &&
          act_reg[scm_pkg::SCM_FMT_SYNC +: 2] == 2'(scm_pkg::SCM_FLAG),
        framing_err_evt && !is_sync,
        overrun_evt,
        parity_err_evt && act_reg[scm_pkg::SCM_FMT_PAR] &&
          rx_mode == 2'(scm_pkg::SCM_RX_ALL_PE)};
    end
  end

  // First-character arming and its pending request
  always_ff @(posedge clk) begin
    if (srst || chan_rst) begin
      first_armed_reg <= 1'b1;
      first_pend_reg <= 1'b0;
    end else begin
      if (cmd_wr && wdata[scm_pkg::SCM_CMD_POS +: 3] ==
          scm_pkg::SCM_CMD_NEXT_CHAR) begin
        first_armed_reg <= 1'b1;
      end else if (rx_mode == 2'(scm_pkg::SCM_RX_FIRST) &&
          first_armed_reg && rx_char_avail) begin
        first_armed_reg <= 1'b0;
      end
      if (rx_mode == 2'(scm_pkg::SCM_RX_FIRST) && first_armed_reg &&
          rx_char_avail) begin
        first_pend_reg <= 1'b1;
      end else if (rx_char_read ||
          rx_mode == 2'(scm_pkg::SCM_RX_OFF)) begin
        first_pend_reg <= 1'b0;
      end
    end
  end

  // Transmit pending: empty sets, command or load clears
  always_ff @(posedge clk) begin
    if (srst || chan_rst) begin
      tx_pend_reg <= 1'b0;
    end else if (tx_empty_evt && interrupt_handshake_control_reg[scm_pkg::SCM_INT_TXIE]) begin
      tx_pend_reg <= 1'b1;
    end else if (tx_load || !interrupt_handshake_control_reg[scm_pkg::SCM_INT_TXIE] ||
        (cmd_wr && wdata[scm_pkg::SCM_CMD_POS +: 3] ==
        scm_pkg::SCM_CMD_TX_INT_RESET)) begin
      tx_pend_reg <= 1'b0;
    end
  end

  // Receive requests are levels so re-enabling raises at once
  always_comb begin
    pend = 4'h0;
    pend[scm_pkg::SCM_SRC_TX] = tx_pend_reg;
    pend[scm_pkg::SCM_SRC_EXT] = ext_status_pend;
    if (rx_mode != 2'(scm_pkg::SCM_RX_OFF)) begin
      pend[scm_pkg::SCM_SRC_SPECIAL] = special;
      if (rx_mode == 2'(scm_pkg::SCM_RX_FIRST)) begin
        pend[scm_pkg::SCM_SRC_RX] = first_pend_reg && !special;
      end else begin
        pend[scm_pkg::SCM_SRC_RX] = rx_char_avail;
      end
    end
  end

  assign pend_a = IS_CH_A ? pend : other_pend;
  assign pend_b = IS_CH_A ? other_pend : pend;

  scm_vector u_vector (
    .pend_a(pend_a),
    .pend_b(pend_b),
    .any(enc_any),
    .src(enc_src)
  );

  assign tx_trig = tx_empty_evt && interrupt_handshake_control_reg[scm_pkg::SCM_INT_TRANSMIT_REQUEST_STROBE];
  assign rx_trig = rx_char_evt && interrupt_handshake_control_reg[scm_pkg::SCM_INT_RECEIVE_REQUEST_STROBE] &&
    !(rx_mode == 2'(scm_pkg::SCM_RX_FIRST) && special);

  scm_strobe u_tx_strobe (
    .clk(clk),
    .srst(srst),
    .trig(tx_trig),
    .strobe_n(transmit_request_strobe)
  );

  scm_strobe u_rx_strobe (
    .clk(clk),
    .srst(srst),
    .trig(rx_trig),
    .strobe_n(receive_request_strobe)
  );

  // Decoded format outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      clock_ratio <= 2'(scm_pkg::SCM_X1);
      start_detect_en <= 1'b0;
      sync_active <= 1'b0;
      sync_mode <= 2'(scm_pkg::SCM_SYNC8);
      stop_bits <= 2'(scm_pkg::SCM_STOP_SYNC);
      parity_en <= 1'b0;
      parity_even <= 1'b0;
      rx_keep_parity <= 1'b0;
      tx_parity_bit <= 1'b0;
    end else begin
      clock_ratio <= act_reg[scm_pkg::SCM_FMT_RATE +: 2];
      start_detect_en <= act_reg[scm_pkg::SCM_FMT_RATE +: 2] !=
        2'(scm_pkg::SCM_X1);
      sync_active <= is_sync;
      sync_mode <= is_sync ? act_reg[scm_pkg::SCM_FMT_SYNC +: 2] :
        2'(scm_pkg::SCM_SYNC8);
      stop_bits <= act_reg[scm_pkg::SCM_FMT_STOP +: 2];
      parity_en <= act_reg[scm_pkg::SCM_FMT_PAR];
      parity_even <= act_reg[scm_pkg::SCM_FMT_PAR] &&
        act_reg[scm_pkg::SCM_FMT_EVEN];
      rx_keep_parity <= act_reg[scm_pkg::SCM_FMT_PAR] &&
        !rx_eight_bits;
      tx_parity_bit <= act_reg[scm_pkg::SCM_FMT_PAR] &&
        scm_parity(tx_char, act_reg[scm_pkg::SCM_FMT_EVEN]);
    end
  end

  // CRC selection, holding, interrupt and vector outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      polynomial_select <= 1'b0;
      crc_preset_ones <= 1'b0;
      rx_hold_data <= 1'b0;
      chan_pend <= 4'h0;
      sav_out <= 1'b0;
      int_req <= 1'b0;
      vector_out <= scm_pkg::SCM_VEC_UNPROG;
    end else begin
      polynomial_select <= is_sync &&
        interrupt_handshake_control_reg[scm_pkg::SCM_INT_POLY];
      crc_preset_ones <= is_sync &&
        act_reg[scm_pkg::SCM_FMT_SYNC +: 2] ==
        2'(scm_pkg::SCM_FLAG);
      rx_hold_data <= rx_mode == 2'(scm_pkg::SCM_RX_FIRST) &&
        special;
      chan_pend <= pend;
      sav_out <= interrupt_handshake_control_reg[scm_pkg::SCM_INT_SAV];
      int_req <= pend != 4'h0;
      if (!vec_prog_reg) begin
        vector_out <= scm_pkg::SCM_VEC_UNPROG;
      end else if (sav_eff && enc_any) begin
        vector_out <= vector_reg;
        vector_out[scm_pkg::SCM_VEC_SRC_LSB +: 3] <= enc_src;
      end else begin
        vector_out <= vector_reg;
      end
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      if (addr == scm_pkg::SCM_OFS_FORMAT) begin
        rdata <= fmt_reg;
      end else if (addr == scm_pkg::SCM_OFS_INTERRUPT_HANDSHAKE_CONTROL) begin
        rdata <= interrupt_handshake_control_reg;
      end else if (addr == scm_pkg::SCM_OFS_VECTOR) begin
        rdata <= vector_out;
      end else if (addr == scm_pkg::SCM_OFS_STATUS) begin
        rdata <= {err_reg, 2'h0,
          rx_mode == 2'(scm_pkg::SCM_RX_FIRST) && special, sav_eff};
      end else begin
        rdata <= 8'h00;
      end
    end else begin
      rdata <= 8'h00;
    end
  end

  // Checks
  a_reset_clears: assert property (@(posedge clk)
    srst |=> fmt_reg == 8'h00 && interrupt_handshake_control_reg == 8'h00)
    else $error("control registers not cleared by reset");
  a_chan_reset_clears: assert property (@(posedge clk) disable iff (srst)
    chan_rst |=> fmt_reg == 8'h00 && interrupt_handshake_control_reg == 8'h00)
    else $error("control registers not cleared by channel reset");
  a_ratio_follows: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> clock_ratio == $past(act_reg[7:6]))
    else $error("clock ratio does not follow active format");
  a_start_detect_x1: assert property (@(posedge clk) disable iff (srst)
    clock_ratio == 2'h0 |-> !start_detect_en)
    else $error("start detection enabled at x1");
  a_sync_stop_code: assert property (@(posedge clk) disable iff (srst)
    sync_active |-> stop_bits == 2'h0)
    else $error("sync operation without sync stop code");
  a_parity_sense_off: assert property (@(posedge clk) disable iff (srst)
    !parity_en |-> !parity_even && !tx_parity_bit)
    else $error("parity sense active while parity disabled");
  a_crc_preset_sync: assert property (@(posedge clk) disable iff (srst)
    crc_preset_ones |-> sync_mode == 2'h2 && sync_active)
    else $error("ones preset outside flag mode");
  a_poly_async_off: assert property (@(posedge clk) disable iff (srst)
    !$past(is_sync) |-> !polynomial_select)
    else $error("polynomial select active in async mode");
  a_tx_strobe_three: assert property (@(posedge clk) disable iff (srst)
    $fell(transmit_request_strobe) |->
    !transmit_request_strobe [*3] ##1
    (transmit_request_strobe || $past(tx_trig)))
    else $error("transmit strobe not three cycles low");
  a_tx_strobe_cause: assert property (@(posedge clk) disable iff (srst)
    $fell(transmit_request_strobe) |-> $past(tx_trig))
    else $error("transmit strobe without enabled empty event");
  a_rx_strobe_three: assert property (@(posedge clk) disable iff (srst)
    $fell(receive_request_strobe) |->
    $past(rx_trig) ##0 !receive_request_strobe [*3])
    else $error("receive strobe wrong length or cause");
  a_rx_off_quiet: assert property (@(posedge clk) disable iff (srst)
    rx_mode == 2'h0 |-> pend[3:2] == 2'h0)
    else $error("receive request while receive interrupts disabled");
  a_err_reset_clear: assert property (@(posedge clk) disable iff (srst)
    err_rst && !overrun_evt && !parity_err_evt && !framing_err_evt &&
    !end_of_frame_evt |=> err_reg == 4'h0)
    else $error("error reset did not clear latched flags");
  a_overrun_latch: assert property (@(posedge clk) disable iff (srst)
    overrun_evt && !chan_rst |=> err_reg[1])
    else $error("overrun not latched");
  a_unprog_vector: assert property (@(posedge clk) disable iff (srst)
    !$past(vec_prog_reg) |-> vector_out == 8'h0f)
    else $error("unprogrammed vector is not 0fh");
  a_tx_pend_set: assert property (@(posedge clk) disable iff (srst)
    tx_empty_evt && interrupt_handshake_control_reg[1] && !chan_rst |=> tx_pend_reg)
    else $error("transmit empty did not raise request");
  c_first_char: cover property (@(posedge clk) disable iff (srst)
    rx_mode == 2'h1 && first_pend_reg);
  c_variable_vector: cover property (@(posedge clk) disable iff (srst)
    sav_eff && enc_any && vec_prog_reg);
  c_held_special: cover property (@(posedge clk) disable iff (srst)
    rx_hold_data ##1 err_rst);
endmodule : scm_channel

/* bench/scm_host_model.sv */
// Host bus master model that programs the channel registers
`timescale 1ns/1ns
module scm_host_model (
  input wire logic clk,
  output logic [2:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  initial begin
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Released data shows junk
    wdata <= ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // Format always before interrupt control
  task automatic setup(input logic [7:0] fmt, input logic [7:0] ictl);
    wr_reg(scm_pkg::SCM_OFS_FORMAT, fmt);
    wr_reg(scm_pkg::SCM_OFS_INTERRUPT_HANDSHAKE_CONTROL, ictl);
  endtask : setup
endmodule : scm_host_model

/* bench/scm_channel_test.sv */
// Self-checking bench for one channel of format and interrupt control
`timescale 1ns/1ns
module scm_channel_test;
  logic clk, srst, cb, rx8, avail, extp, osav, wr, rd;
  logic [7:0] transmit_shift_clock, ev, wdata, rdata, vec, d;
  logic [3:0] opend, pend;
  logic [2:0] addr;
  logic [1:0] ratio, smode, stops;
  logic sd, sa, pe, pev, txp, keep, poly, ones, hold, txs_n, rxs_n;
  logic irq, sav;
  int mismatches, cmp_count, ct, cr;
  // Format byte beside its decode; no x1 with 1.5 stops, x1 when sync
  logic [18:0] rows [7] = '{
    {8'h00, 11'h080}, {8'h10, 11'h0a0}, {8'h20, 11'h0c1},
    {8'h30, 11'h0e0}, {8'h47, 11'h30e}, {8'hb9, 11'h514},
    {8'hce, 11'h718}};
  scm_channel #(.IS_CH_A(1'b1)) i_scm_channel (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .char_boundary(cb), .rx_eight_bits(rx8),
    .tx_char(transmit_shift_clock), .tx_empty_evt(ev[0]), .tx_load(ev[1]),
    .rx_char_evt(ev[2]), .rx_char_read(ev[3]), .overrun_evt(ev[4]),
    .parity_err_evt(ev[5]), .framing_err_evt(ev[6]),
    .end_of_frame_evt(ev[7]), .rx_char_avail(avail),
    .ext_status_pend(extp), .other_sav(osav), .other_pend(opend),
    .clock_ratio(ratio), .start_detect_en(sd), .sync_active(sa),
    .sync_mode(smode), .stop_bits(stops), .parity_en(pe),
    .parity_even(pev), .tx_parity_bit(txp), .rx_keep_parity(keep),
    .polynomial_select(poly), .crc_preset_ones(ones),
    .rx_hold_data(hold), .transmit_request_strobe(txs_n),
    .receive_request_strobe(rxs_n), .chan_pend(pend), .sav_out(sav),
    .int_req(irq), .vector_out(vec));
  scm_host_model i_scm_host_model (.clk(clk), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic wreg(input logic [2:0] a, input logic [7:0] v);
    i_scm_host_model.wr_reg(a, v);
  endtask : wreg
  task automatic rchk(input string s, input logic [2:0] a,
                      input logic [7:0] e);
    logic [7:0] r;
    i_scm_host_model.rd_reg(a, r);
    check(s, r, e);
  endtask : rchk
  task automatic fire(input logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
  endtask : fire
  // Counts low cycles of both strobes after an event
  task automatic lows;
    ct = 0;
    cr = 0;
    repeat (6) begin
      #1;
      ct += (txs_n === 1'b0);
      cr += (rxs_n === 1'b0);
      @(posedge clk);
    end
  endtask : lows
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    {srst, cb, rx8, avail, extp, osav} = 6'h30;
    {transmit_shift_clock, ev, opend} = {8'h07, 8'h00, 4'h0};
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    wt(1);
    check("vec_rst", vec, 8'h0f);
    check("strobes", {txs_n, rxs_n}, 2'h3);
    rchk("fmt_rst", 3'h0, 8'h00);
    rchk("ictl_rst", 3'h1, 8'h00);
    rchk("unmapped", 3'h7, 8'h00);
    foreach (rows[i]) begin
      i_scm_host_model.setup(rows[i][18:11], 8'h00);
      wt(3);
      check("fmt", {ratio, sd, sa, smode, stops, pe, pev, ones},
            rows[i][10:0]);
      check("keep", keep, rows[i][2]);
      rchk("fmt_rd", 3'h0, rows[i][18:11]);
    end
    @(posedge clk) cb <= 1'b0;
    wreg(3'h0, 8'h47);
    wt(4);
    check("fmt_busy", ratio, 2'h3);
    @(posedge clk) cb <= 1'b1;
    wt(4);
    check("fmt_new", ratio, 2'h1);
    check("par_even", txp, 1'b1);
    wreg(3'h0, 8'h45);
    wt(4);
    check("par_odd", txp, 1'b0);
    @(posedge clk) rx8 <= 1'b1;
    wt(3);
    check("keep8", keep, 1'b0);
    i_scm_host_model.setup(8'h45, 8'h80);
    wt(4);
    check("poly_async", poly, 1'b0);
    i_scm_host_model.setup(8'h00, 8'h80);
    wt(4);
    check("poly_sync", {poly, ones}, 2'h2);
    i_scm_host_model.setup(8'h47, 8'h40);
    fire(8'h01);
    lows();
    check("tx_lows", {ct[7:0], cr[7:0]}, 16'h0300);
    fire(8'h04);
    lows();
    check("rx_off", cr, 0);
    wreg(3'h1, 8'h60);
    fire(8'h05);
    lows();
    check("both", {ct[7:0], cr[7:0]}, 16'h0303);
    wreg(3'h3, 8'h60);
    wreg(3'h1, 8'h02);
    fire(8'h01);
    wt(2);
    check("tx_int", {pend, irq, vec}, 13'h0360);
    @(posedge clk) osav <= 1'b1;
    wt(2);
    check("vec_or", vec, 8'h68);
    @(posedge clk) osav <= 1'b0;
    wreg(3'h1, 8'h06);
    wt(3);
    check("vec_sav", {sav, vec}, 9'h168);
    wreg(3'h2, 8'h28);
    wt(3);
    check("tx_clr", {pend, irq, vec}, 13'h0060);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) opend <= 4'(1 << k);
      wt(2);
      check("vec_b", vec, 8'h60 | 8'(k << 1));
    end
    @(posedge clk) {opend, extp} <= 5'h01;
    wt(2);
    check("vec_ext", vec, 8'h6a);
    @(posedge clk) {extp, avail} <= 2'h1;
    wreg(3'h1, 8'h04);
    wt(3);
    check("rx_off", pend, 4'h0);
    wreg(3'h1, 8'h14);
    wt(3);
    check("rx_back", {pend, vec}, 12'h46c);
    @(posedge clk) avail <= 1'b0;
    fire(8'h20);
    wt(2);
    check("vec_spc", vec, 8'h6e);
    rchk("par_lat", 3'h4, 8'h11);
    wreg(3'h2, 8'h30);
    rchk("err_rst", 3'h4, 8'h01);
    wreg(3'h1, 8'h1c);
    fire(8'h20);
    rchk("par_ign", 3'h4, 8'h01);
    fire(8'h10);
    rchk("ovr_lat", 3'h4, 8'h21);
    wreg(3'h2, 8'h30);
    fire(8'h40);
    rchk("frm_lat", 3'h4, 8'h41);
    wreg(3'h2, 8'h30);
    wreg(3'h0, 8'h20);
    wt(2);
    fire(8'hc0);
    rchk("eof_lat", 3'h4, 8'h81);
    wreg(3'h2, 8'h30);
    wreg(3'h1, 8'h28);
    @(posedge clk) avail <= 1'b1;
    wt(3);
    check("first", {pend, irq}, 5'h09);
    @(posedge clk) avail <= 1'b0;
    fire(8'h08);
    wt(2);
    check("first_rd", pend, 4'h0);
    wreg(3'h2, 8'h20);
    @(posedge clk) avail <= 1'b1;
    fire(8'h04);
    lows();
    check("rearm", {pend, cr[3:0]}, 8'h43);
    @(posedge clk) avail <= 1'b0;
    fire(8'h08);
    fire(8'h10);
    wt(2);
    check("held", {pend, hold}, 5'h11);
    fire(8'h04);
    lows();
    check("rx_block", cr, 0);
    wreg(3'h2, 8'h30);
    wt(2);
    check("unheld", hold, 1'b0);
    wreg(3'h2, 8'h20);
    wreg(3'h2, 8'h18);
    wt(3);
    rchk("fmt_ch", 3'h0, 8'h00);
    rchk("ictl_ch", 3'h1, 8'h00);
    check("vec_keep", vec, 8'h60);
    @(posedge clk) srst <= 1'b1;
    wt(2);
    @(posedge clk) srst <= 1'b0;
    wt(2);
    rchk("vec_hw", 3'h3, 8'h0f);
    report_and_stop();
  end
endmodule : scm_channel_test
